/* File: verilog/flash_protect_pkg.sv */
`default_nettype none
package flash_protect_pkg;

  // flash geometry: 32 KB, 1 KB erase units, 2 KB protection regions
  localparam int FLASH_BYTES = 32768;
  localparam int FLASH_ADDR_W = 15;
  localparam int WORD_LSB = 2;
  localparam int WORD_IDX_W = FLASH_ADDR_W - WORD_LSB;
  localparam int UNIT_LSB = 10;
  localparam int UNIT_MSB = 14;
  localparam int UNIT_W = UNIT_MSB - UNIT_LSB + 1;
  localparam int REGION_LSB = 11;
  localparam int REGION_MSB = 14;
  localparam int REGION_W = REGION_MSB - REGION_LSB + 1;
  localparam int N_REGIONS = 16;
  localparam int UNIT_CNT_W = UNIT_LSB - WORD_LSB;
  localparam int DATA_W = 32;

  // an erased word reads as all ones
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [UNIT_CNT_W-1:0] UNIT_LAST_WORD = 8'hFF;

  // static memory
  localparam int SRAM_ADDR_W = 13;
  localparam int SRAM_WORDS_DEF = 2048;
  localparam int SRAM_IDX_W = SRAM_ADDR_W - WORD_LSB;

  typedef enum logic [2:0] {
    ACC_FETCH,
    ACC_DATA_RD,
    ACC_DEBUG_RD,
    ACC_PROGRAM,
    ACC_ERASE
  } acc_kind_t;

  typedef struct packed {
    logic valid;
    acc_kind_t kind;
    logic [FLASH_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } flash_req_t;

  typedef struct packed {
    logic valid;
    logic denied;
    logic [DATA_W-1:0] data;
  } flash_rsp_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [SRAM_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sram_req_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } sram_rsp_t;

  // protection region of a byte address
  function automatic logic [REGION_W-1:0] region_of(input logic [FLASH_ADDR_W-1:0] a);
    return a[REGION_MSB:REGION_LSB];
  endfunction

  // erase unit of a byte address
  function automatic logic [UNIT_W-1:0] unit_of(input logic [FLASH_ADDR_W-1:0] a);
    return a[UNIT_MSB:UNIT_LSB];
  endfunction

endpackage
`default_nettype wire

/* File: verilog/flash_perm_check.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_perm_check
  import flash_protect_pkg::*;
(
  input wire acc_kind_t kind,
  input wire logic [FLASH_ADDR_W-1:0] addr,
  input wire logic [N_REGIONS-1:0] ro_region,
  input wire logic [N_REGIONS-1:0] xo_region,
  output logic allow
);

  // both erase units of a region look up the same region bit
  wire logic [REGION_W-1:0] region = region_of(addr);
  wire logic ro_hit = ro_region[region];
  wire logic xo_hit = xo_region[region];
  wire logic locked = ro_hit | xo_hit;

  // fetch always passes; reads only lose to execute-only; changes lose to either mark
  assign allow = (kind == ACC_FETCH) ? 1'b1 :
                 (kind == ACC_DATA_RD) ? !xo_hit :
                 (kind == ACC_DEBUG_RD) ? !xo_hit :
                 (kind == ACC_PROGRAM) ? !locked :
                 (kind == ACC_ERASE) ? !locked :
                 1'b0;

endmodule
`default_nettype wire

/* File: verilog/flash_erase_protect_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_erase_protect_ctrl
  import flash_protect_pkg::*;
#(
  parameter int SRAM_WORDS = SRAM_WORDS_DEF
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire flash_req_t flash_req,
  output logic flash_ready,
  output flash_rsp_t flash_rsp,
  input wire logic [N_REGIONS-1:0] ro_region,
  input wire logic [N_REGIONS-1:0] xo_region,
  input wire sram_req_t sram_req,
  output sram_rsp_t sram_rsp
);

  typedef enum logic {
    ST_IDLE,
    ST_ERASING
  } ctrl_state_t;

  // storage; contents are not reset, as in a real array
  logic [DATA_W-1:0] flash_mem [0:(1 << WORD_IDX_W)-1];
  logic [DATA_W-1:0] sram_mem [0:SRAM_WORDS-1];

  ctrl_state_t state_ff;
  ctrl_state_t nxt_state;
  logic [UNIT_W-1:0] erase_unit_ff;
  logic [UNIT_CNT_W-1:0] erase_cnt_ff;
  logic ready_ff;
  flash_rsp_t rsp_ff;
  flash_rsp_t nxt_rsp;
  sram_rsp_t sram_rsp_ff;
  logic allow;

  // permission lookup for the request on the port
  flash_perm_check u_perm (
    .kind(flash_req.kind),
    .addr(flash_req.addr),
    .ro_region(ro_region),
    .xo_region(xo_region),
    .allow(allow)
  );

  // request decode; requests while busy erasing are not taken
  wire logic take = flash_req.valid & ready_ff;
  wire logic is_read = (flash_req.kind == ACC_FETCH) | (flash_req.kind == ACC_DATA_RD) |
                       (flash_req.kind == ACC_DEBUG_RD);
  wire logic is_prog = flash_req.kind == ACC_PROGRAM;
  wire logic is_erase = flash_req.kind == ACC_ERASE;
  wire logic prog_go = take & is_prog & allow;
  wire logic erase_go = take & is_erase & allow;
  wire logic [WORD_IDX_W-1:0] word_idx = flash_req.addr[FLASH_ADDR_W-1:WORD_LSB];
  wire logic [UNIT_W-1:0] req_unit = unit_of(flash_req.addr);
  // the erase walk stays inside one unit: unit bits are held, only low bits count
  wire logic [WORD_IDX_W-1:0] erase_idx = {erase_unit_ff, erase_cnt_ff};
  wire logic erase_last = (state_ff == ST_ERASING) & (erase_cnt_ff == UNIT_LAST_WORD);
  wire logic [SRAM_IDX_W-1:0] sram_idx = sram_req.addr[SRAM_ADDR_W-1:WORD_LSB];

  // data selections as named wires; a refused read is zeroed before the register
  wire logic [DATA_W-1:0] arr_word = flash_mem[word_idx];
  wire logic [DATA_W-1:0] rd_word = allow ? arr_word : ZERO_WORD;
  // program data is anded in: bits only go from one to zero
  wire logic [DATA_W-1:0] prog_word = arr_word & flash_req.wdata;
  wire logic sram_wr = sram_req.valid & sram_req.write;
  wire logic sram_rd = sram_req.valid & !sram_req.write;
  // a write answers with zero data so no stale word leaks out
  wire logic [DATA_W-1:0] sram_rd_word = sram_rd ? sram_mem[sram_idx] : ZERO_WORD;
  // ready follows the next state so it drops on the edge that takes an allowed erase
  wire logic nxt_ready = nxt_state == ST_IDLE;

  // state sequencing
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (erase_go)
        begin
          nxt_state = ST_ERASING;
        end
      end
      ST_ERASING:
      begin
        if (erase_last)
        begin
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // answer for the current cycle; a refused read never carries array data
  always_comb
  begin
    nxt_rsp = '0;
    if (take & is_read)
    begin
      nxt_rsp.valid = 1'b1;
      nxt_rsp.denied = !allow;
      nxt_rsp.data = rd_word;
    end
    else if (take & is_prog)
    begin
      nxt_rsp.valid = 1'b1;
      nxt_rsp.denied = !allow;
    end
    else if (take & is_erase & !allow)
    begin
      nxt_rsp.valid = 1'b1;
      nxt_rsp.denied = 1'b1;
    end
    else if (erase_last)
    begin
      nxt_rsp.valid = 1'b1; // an allowed erase is answered only when the whole unit is done
    end
  end

  // control registers; ready stays low through reset so nothing is taken then
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_ff <= ST_IDLE;
      ready_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      ready_ff <= nxt_ready;
    end
  end

  // answer register; every answer is a one-cycle pulse
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      rsp_ff <= '0;
    end
    else
    begin
      rsp_ff <= nxt_rsp;
    end
  end

  // erase walk position; a fresh erase always starts at word zero of its unit
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      erase_unit_ff <= '0;
      erase_cnt_ff <= '0;
    end
    else if (erase_go)
    begin
      erase_unit_ff <= req_unit;
      erase_cnt_ff <= '0;
    end
    else if (state_ff == ST_ERASING)
    begin
      erase_cnt_ff <= erase_cnt_ff + 1'b1;
    end
  end

  // array writes; walk and program never meet, as ready is low while erasing
  always_ff @(posedge sys_clk)
  begin
    if (state_ff == ST_ERASING)
    begin
      flash_mem[erase_idx] <= ERASED_WORD;
    end
    else if (prog_go)
    begin
      flash_mem[word_idx] <= prog_word;
    end
  end

  // static memory: read or write answered on the next edge
  always_ff @(posedge sys_clk)
  begin
    if (sram_wr)
    begin
      sram_mem[sram_idx] <= sram_req.wdata;
    end
  end

  // static memory answer, one clock after every request
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      sram_rsp_ff <= '0;
    end
    else
    begin
      sram_rsp_ff.valid <= sram_req.valid;
      sram_rsp_ff.data <= sram_rd_word;
    end
  end

  // every output comes straight from a register
  assign flash_ready = ready_ff;
  assign flash_rsp = rsp_ff;
  assign sram_rsp = sram_rsp_ff;

endmodule
`default_nettype wire

/* File: verification/flash_protect_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_protect_assertions
  import flash_protect_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire flash_req_t flash_req,
  input wire logic flash_ready,
  input wire flash_rsp_t flash_rsp,
  input wire logic [N_REGIONS-1:0] ro_region,
  input wire logic [N_REGIONS-1:0] xo_region,
  input wire sram_req_t sram_req,
  input wire sram_rsp_t sram_rsp
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // taken request, its kind class and the protection of its region
  wire logic tk = flash_req.valid && flash_ready;
  wire logic ro_hit = ro_region[flash_req.addr[14:11]];
  wire logic xo_hit = xo_region[flash_req.addr[14:11]];
  wire logic rd = tk && (flash_req.kind == ACC_DATA_RD || flash_req.kind == ACC_DEBUG_RD);
  wire logic chg = tk && (flash_req.kind == ACC_PROGRAM || flash_req.kind == ACC_ERASE);
  // an allowed erase walks 256 words, so the answer window is narrow
  sequence s_erase_go;
    chg && flash_req.kind == ACC_ERASE && !ro_hit && !xo_hit;
  endsequence
  sequence s_erase_done;
    ##[255:258] flash_rsp.valid && !flash_rsp.denied && flash_ready;
  endsequence
  property p_quick; tk && flash_req.kind != ACC_ERASE |=> flash_rsp.valid; endproperty
  a_quick: assert property (p_quick) else $error("flash answer late");
  property p_busy; s_erase_go |=> !flash_ready [*8]; endproperty
  a_busy: assert property (p_busy) else $error("ready during erase");
  property p_done; s_erase_go |-> s_erase_done; endproperty
  a_done: assert property (p_done) else $error("erase end wrong");
  property p_lock; chg && (ro_hit || xo_hit) |=> flash_rsp.valid && flash_rsp.denied; endproperty
  a_lock: assert property (p_lock) else $error("change not refused");
  property p_hide; rd && xo_hit |=> flash_rsp.denied && flash_rsp.data == ZERO_WORD; endproperty
  a_hide: assert property (p_hide) else $error("hidden data read");
  property p_rd_ok; rd && !xo_hit |=> !flash_rsp.denied; endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("read refused");
  property p_fetch; tk && flash_req.kind == ACC_FETCH |=> !flash_rsp.denied; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch refused");
  property p_sram; sram_req.valid |=> sram_rsp.valid; endproperty
  a_sram: assert property (p_sram) else $error("sram answer late");
  property p_sram_wr; sram_req.valid && sram_req.write |=> sram_rsp.data == ZERO_WORD; endproperty
  a_sram_wr: assert property (p_sram_wr) else $error("sram write data");
endmodule
bind flash_erase_protect_ctrl flash_protect_assertions i_chk (.sys_clk, .reset_n, .flash_req,
  .flash_ready, .flash_rsp, .ro_region, .xo_region, .sram_req, .sram_rsp);
`default_nettype wire

/* File: verification/cpu_access_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cpu_access_model
  import flash_protect_pkg::*;
(
  input wire logic sys_clk,
  input wire logic flash_ready,
  input wire flash_rsp_t flash_rsp,
  output flash_req_t flash_req
);
  initial flash_req = '0;
  // hold the request until a rising edge sees ready; the released bus shows junk, not old data
  task automatic access(input acc_kind_t k, input logic [FLASH_ADDR_W-1:0] a,
    input logic [DATA_W-1:0] w, output flash_rsp_t r, output int n);
    @(negedge sys_clk);
    flash_req = '{1'b1, k, a, w};
    for (int i = 0; i < 300 && flash_ready !== 1'b1; i++) @(negedge sys_clk);
    @(posedge sys_clk);
    @(negedge sys_clk);
    flash_req = '{1'b0, k, ~a, ~w};
    // n counts the falling edges waited after the one that follows the taking edge
    for (n = 0; n < 300 && flash_rsp.valid !== 1'b1; n++) @(negedge sys_clk);
    r = flash_rsp;
  endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) cmp_count++; if ((e) !== (s)) begin bad_count++; $display("unexpected %s exp %h got %h", n, e, s); end
module testbench
  import flash_protect_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [N_REGIONS-1:0] ro_region = '0;
  logic [N_REGIONS-1:0] xo_region = '0;
  flash_req_t flash_req;
  logic flash_ready;
  flash_rsp_t flash_rsp;
  sram_req_t sram_req = '0;
  sram_rsp_t sram_rsp;
  int bad_count = 0;
  int cmp_count = 0;
  initial forever #10 sys_clk = ~sys_clk;
  flash_erase_protect_ctrl i_dut (.sys_clk, .reset_n, .flash_req, .flash_ready, .flash_rsp,
    .ro_region, .xo_region, .sram_req, .sram_rsp);
  cpu_access_model i_cpu (.sys_clk, .flash_ready, .flash_rsp, .flash_req);
  // single exit for normal end and for a wait that ran out
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one flash access through the model, then judge its answer
  task automatic go(input acc_kind_t k, input logic [14:0] a, input logic [31:0] w,
    input logic d, input logic [31:0] e);
    flash_rsp_t r;
    int n;
    i_cpu.access(k, a, w, r, n);
    if (r.valid !== 1'b1)
    begin
      bad_count++;
      end_of_test();
    end
    `CHK("denied", d, r.denied)
    `CHK("data", e, r.data)
    // an allowed erase walks one word per clock; everything else answers at once
    `CHK("wait", (k == ACC_ERASE && !d) ? int'(UNIT_LAST_WORD) + 1 : 0, n)
  endtask
  // unit edges, and a unit kept across its neighbour's erase
  task automatic t_erase();
    go(ACC_ERASE, 15'h0400, '0, 1'b0, '0);
    go(ACC_ERASE, 15'h0000, '0, 1'b0, '0);
    go(ACC_DATA_RD, 15'h03fc, '0, 1'b0, 32'hffff_ffff);
    go(ACC_DATA_RD, 15'h0400, '0, 1'b0, 32'hffff_ffff);
    go(ACC_PROGRAM, 15'h0400, 32'h1234_5678, 1'b0, '0);
    go(ACC_ERASE, 15'h03fc, '0, 1'b0, '0);
    go(ACC_DATA_RD, 15'h0400, '0, 1'b0, 32'h1234_5678);
    go(ACC_PROGRAM, 15'h0400, 32'hffff_00ff, 1'b0, '0);
    go(ACC_FETCH, 15'h0400, '0, 1'b0, 32'h1234_0078);
    go(ACC_ERASE, 15'h7c00, '0, 1'b0, '0);
    go(ACC_DATA_RD, 15'h7ffc, '0, 1'b0, 32'hffff_ffff);
  endtask
  // read-only regions 0 and 15 refuse changes, keep data reads; region 1 stays free
  task automatic t_ro();
    ro_region = 16'h8001;
    go(ACC_ERASE, 15'h7800, '0, 1'b1, '0);
    go(ACC_PROGRAM, 15'h0400, '0, 1'b1, '0);
    go(ACC_ERASE, 15'h07fc, '0, 1'b1, '0);
    go(ACC_DATA_RD, 15'h0400, '0, 1'b0, 32'h1234_0078);
    go(ACC_ERASE, 15'h0800, '0, 1'b0, '0);
    ro_region = '0;
  endtask
  // execute-only region 0 answers fetch alone
  task automatic t_xo();
    xo_region = 16'h0001;
    go(ACC_FETCH, 15'h0400, '0, 1'b0, 32'h1234_0078);
    go(ACC_DATA_RD, 15'h0400, '0, 1'b1, '0);
    go(ACC_DEBUG_RD, 15'h0400, '0, 1'b1, '0);
    go(ACC_PROGRAM, 15'h0400, '0, 1'b1, '0);
    go(ACC_ERASE, 15'h0000, '0, 1'b1, '0);
    go(ACC_DATA_RD, 15'h0800, '0, 1'b0, 32'hffff_ffff);
    xo_region = '0;
    go(ACC_DATA_RD, 15'h0400, '0, 1'b0, 32'h1234_0078);
  endtask
  // write then read the same word back to back
  task automatic t_sram();
    sram_req = '{1'b1, 1'b1, 13'h0010, 32'ha5a5_5a5a};
    @(negedge sys_clk);
    `CHK("sram wr", 33'h1_0000_0000, sram_rsp)
    sram_req = '{1'b1, 1'b0, 13'h0010, 32'h0000_0000};
    @(negedge sys_clk);
    `CHK("sram rd", 33'h1_a5a5_5a5a, sram_rsp)
    sram_req = '0;
  endtask
  initial
  begin
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_erase();
    t_ro();
    t_xo();
    t_sram();
    end_of_test();
  end
endmodule
`default_nettype wire
